/* File: rtl/vlpf_top.sv */
// vlan port classification, egress tpid choice and private vlan filter
//
// Contract
// - untagged frames get port default vid, forwarded
// - tag-blind port pushes tag on 0x8100 frames
// - tag-blind and customer drop non-0x8100 tags
// - customer port forwards 0x8100 tagged frames
// - service ports drop tags other than 0x88A8
// - tag-blind and customer transmit tpid 0x8100
// - service port transmits tpid 0x88A8
// - custom service port transmits global ethertype
// - tag-blind egress tag set by tagging option
// - forward only if in vlan and private vlan
// - private vlans are source-port masks, vid-free
// - reset: tag-blind, vlan 1, private vlan 1
// - tag-blind: one vlan, many private vlans
// - private vlan ids limited to port range
// - new private vlan starts empty
// - per-port isolation bit, cleared at reset
// - management only from management vlan members
// - ingress filter drops non-member classified vlan
// - tagged-only port drops untagged; reset none
// - egress: untag pvid, tag all, untag all
// - port default vid 1 to 4095, reset 1
`include "vlpf_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module vlpf_top #(
   parameter int NPORT = 8
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rstn,
   input  wire logic [7:0]           av_address,
   input  wire logic                 av_read,
   input  wire logic                 av_write,
   input  wire logic [31:0]          av_writedata,
   output logic      [31:0]          av_readdata,
   output logic                      av_waitrequest,
   input  wire logic                 rx_valid,
   input  wire logic [$clog2(NPORT)-1:0] rx_port,
   input  wire logic                 rx_tagged,
   input  wire vlpf_pkg::vlpf_tpid_t rx_tpid,
   input  wire vlpf_pkg::vlpf_vid_t  rx_vid,
   output logic                      cls_valid_q,
   output logic                      cls_drop_q,
   output logic                      cls_push_q,
   output vlpf_pkg::vlpf_vid_t       cls_vid_q,
   output logic      [NPORT-1:0]     cls_dst_q,
   input  wire logic                 tx_valid,
   input  wire logic [$clog2(NPORT)-1:0] tx_port,
   input  wire vlpf_pkg::vlpf_vid_t  tx_vid,
   output logic                      txo_valid_q,
   output logic                      txo_tag_q,
   output vlpf_pkg::vlpf_tpid_t      txo_tpid_q,
   input  wire logic                 mgmt_valid,
   input  wire logic [$clog2(NPORT)-1:0] mgmt_port,
   output logic                      mgmt_ok_q
);
   import vlpf_pkg::*;
   localparam int PW = $clog2(NPORT);
   localparam int NVID = 4096;

   logic              rs1_q, rs_n_q;
   vlpf_ptype_e       ptype_q [NPORT];
   vlpf_txtag_e       txtag_q [NPORT];
   vlpf_vid_t         pvid_q [NPORT];
   logic [NPORT-1:0]  ifilt_q, tonly_q, iso_q, pv_val_q;
   logic [NPORT-1:0]  pv_mask_q [NPORT];
   logic [NPORT-1:0]  vmem [NVID];
   vlpf_vid_t         vsel_q, mgmt_vid_q;
   logic [PW-1:0]     psel_q;
   logic [15:0]       etype_q, dcnt_q;
   logic              rej_q;
   logic              wr_go, in_port, pv_bad;
   logic [7:0]        port_off, pv_id;
   logic [PW-1:0]     port_idx;
   logic [31:0]       rd_mux;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rs1_q  <= 1'h0;
         rs_n_q <= 1'h0;
      end else begin
         rs1_q  <= 1'h1;
         rs_n_q <= rs1_q;
      end
   end

   // bus decode
   assign wr_go    = av_write && !av_waitrequest;
   assign port_off = av_address - `VLPF_A_PORT0;
   assign port_idx = port_off[PW+1:2];
   assign in_port  = (av_address >= `VLPF_A_PORT0) && ((port_off >> 2) < 8'(NPORT));
   assign pv_id    = av_writedata[`VLPF_F_PVID8];
   assign pv_bad   = (pv_id == 8'h00) || (pv_id > 8'(NPORT));

   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q)
         av_waitrequest <= 1'h1;
      else
         av_waitrequest <= !((av_read || av_write) && av_waitrequest);
   end

   // read mux, unmapped reads return zero
   always_comb begin
      rd_mux = 32'h0;
      if (in_port) begin
         rd_mux[`VLPF_F_TYPE]  = ptype_q[port_idx];
         rd_mux[`VLPF_F_TXTAG] = txtag_q[port_idx];
         rd_mux[`VLPF_F_IFILT] = ifilt_q[port_idx];
         rd_mux[`VLPF_F_TONLY] = tonly_q[port_idx];
         rd_mux[`VLPF_F_PVID]  = pvid_q[port_idx];
      end else begin
         unique case (av_address)
            `VLPF_A_ETYPE: rd_mux[`VLPF_F_ETYPE] = etype_q;
            `VLPF_A_MGMT:  rd_mux[`VLPF_F_VID] = mgmt_vid_q;
            `VLPF_A_ISO:   rd_mux[NPORT-1:0] = iso_q;
            `VLPF_A_STAT: begin
               rd_mux[`VLPF_F_REJ]  = rej_q;
               rd_mux[`VLPF_F_DCNT] = dcnt_q;
            end
            `VLPF_A_VSEL:  rd_mux[`VLPF_F_VID] = vsel_q;
            `VLPF_A_VMASK: rd_mux[NPORT-1:0] = vmem[vsel_q];
            `VLPF_A_PCMD:  rd_mux[`VLPF_F_PVID8] = 8'(psel_q) + 8'h01;
            `VLPF_A_PMASK: begin
               rd_mux[NPORT-1:0]     = pv_mask_q[psel_q];
               rd_mux[`VLPF_F_PVVAL] = pv_val_q[psel_q];
            end
            default: rd_mux = 32'h0;
         endcase
      end
   end

   // read data captured as waitrequest falls
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q)
         av_readdata <= 32'h0;
      else if (av_read && av_waitrequest)
         av_readdata <= rd_mux;
   end

   // per-port settings
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      always_ff @(posedge clk_sys or negedge rs_n_q) begin
         if (!rs_n_q) begin
            ptype_q[p] <= VLPF_UNAWARE;
            txtag_q[p] <= VLPF_UNTAG_PVID;
            pvid_q[p]  <= `VLPF_RST_VID;
            ifilt_q[p] <= 1'h0;
            tonly_q[p] <= 1'h0;
         end else if (wr_go && in_port && port_idx == PW'(p)) begin
            ptype_q[p] <= vlpf_ptype_e'(av_writedata[`VLPF_F_TYPE]);
            if (av_writedata[`VLPF_F_TXTAG] != 2'h3)
               txtag_q[p] <= vlpf_txtag_e'(av_writedata[`VLPF_F_TXTAG]);
            if (av_writedata[`VLPF_F_PVID] != `VLPF_VID_NONE)
               pvid_q[p] <= av_writedata[`VLPF_F_PVID];
            ifilt_q[p] <= av_writedata[`VLPF_F_IFILT];
            tonly_q[p] <= av_writedata[`VLPF_F_TONLY];
         end
      end
   end

   // private vlan entries, id p+1 owns a source-port mask
   for (genvar p = 0; p < NPORT; p++) begin : g_pv
      always_ff @(posedge clk_sys or negedge rs_n_q) begin
         if (!rs_n_q) begin
            pv_val_q[p]  <= (p == 0);
            pv_mask_q[p] <= (p == 0) ? '1 : '0;
         end else if (wr_go && av_address == `VLPF_A_PCMD && !pv_bad
                      && pv_id == 8'(p + 1)) begin
            if (av_writedata[`VLPF_F_PVOP] == `VLPF_OP_NEW) begin
               pv_val_q[p]  <= 1'h1;
               pv_mask_q[p] <= '0;
            end else if (av_writedata[`VLPF_F_PVOP] == `VLPF_OP_DEL) begin
               pv_val_q[p]  <= 1'h0;
               pv_mask_q[p] <= '0;
            end
         end else if (wr_go && av_address == `VLPF_A_PMASK && psel_q == PW'(p))
            pv_mask_q[p] <= av_writedata[NPORT-1:0];
      end
   end

   // selection, global settings, reject flag
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q) begin
         psel_q     <= '0;
         vsel_q     <= `VLPF_RST_VID;
         mgmt_vid_q <= `VLPF_RST_VID;
         etype_q    <= `VLPF_RST_ETY;
         iso_q      <= '0;
         rej_q      <= 1'h0;
      end else if (wr_go) begin
         unique case (av_address)
            `VLPF_A_ETYPE: etype_q <= av_writedata[`VLPF_F_ETYPE];
            `VLPF_A_MGMT:  mgmt_vid_q <= av_writedata[`VLPF_F_VID];
            `VLPF_A_ISO:   iso_q <= av_writedata[NPORT-1:0];
            `VLPF_A_VSEL:  vsel_q <= av_writedata[`VLPF_F_VID];
            `VLPF_A_STAT:  if (av_writedata[`VLPF_F_REJ]) rej_q <= 1'h0;
            `VLPF_A_PCMD: begin
               if (pv_bad)
                  rej_q <= 1'h1;
               else
                  psel_q <= PW'(pv_id - 8'h01);
            end
            default: ;
         endcase
      end
   end

   // vlan membership table, vlan 1 holds every port after reset
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q) begin
         for (int i = 0; i < NVID; i++)
            vmem[i] <= (i == 1) ? '1 : '0;
      end else if (wr_go && av_address == `VLPF_A_VMASK)
         vmem[vsel_q] <= av_writedata[NPORT-1:0];
   end

   // ingress classification
   vlpf_ptype_e      src_ty;
   vlpf_vid_t        src_pvid, c_vid;
   logic             c_drop, c_push, src_in_pv;
   logic [NPORT-1:0] reach, c_dst, c_vmask;
   assign src_ty   = ptype_q[rx_port];
   assign src_pvid = pvid_q[rx_port];
   assign c_vmask  = vmem[c_vid];

   always_comb begin
      c_drop = 1'h0;
      c_push = 1'h0;
      c_vid  = src_pvid;
      if (!rx_tagged)
         c_drop = tonly_q[rx_port];
      else begin
         unique case (src_ty)
            VLPF_UNAWARE: begin
               c_push = (rx_tpid == `VLPF_TPID_C);
               c_drop = !c_push;
            end
            VLPF_CPORT: begin
               c_drop = (rx_tpid != `VLPF_TPID_C);
               c_vid  = rx_vid;
            end
            VLPF_SPORT, VLPF_SCUST: begin
               c_drop = (rx_tpid != `VLPF_TPID_S);
               c_vid  = rx_vid;
            end
         endcase
      end
   end

   // private vlan reach and isolation for the source port
   always_comb begin
      reach = '0;
      for (int p = 0; p < NPORT; p++)
         if (pv_val_q[p] && pv_mask_q[p][rx_port])
            reach = reach | pv_mask_q[p];
      src_in_pv = reach[rx_port];
      c_dst = c_vmask & reach;
      c_dst[rx_port] = 1'h0;
      if (iso_q[rx_port])
         c_dst = c_dst & ~iso_q;
      if (!src_in_pv || !c_vmask[rx_port])
         c_dst = '0;
   end

   // classification result register
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q) begin
         cls_valid_q <= 1'h0;
         cls_drop_q  <= 1'h0;
         cls_push_q  <= 1'h0;
         cls_vid_q   <= `VLPF_VID_NONE;
         cls_dst_q   <= '0;
      end else begin
         cls_valid_q <= rx_valid;
         cls_push_q  <= rx_valid && c_push;
         cls_vid_q   <= c_vid;
         cls_drop_q  <= rx_valid && (c_drop || (ifilt_q[rx_port] && !c_vmask[rx_port]));
         cls_dst_q   <= (rx_valid && !c_drop && !(ifilt_q[rx_port] && !c_vmask[rx_port]))
                        ? c_dst : '0;
      end
   end

   // saturating discard counter
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q)
         dcnt_q <= 16'h0;
      else if (cls_drop_q && dcnt_q != 16'hFFFF)
         dcnt_q <= dcnt_q + 16'h1;
   end

   // egress tpid and tag decision
   vlpf_ptype_e tx_ty;
   assign tx_ty = ptype_q[tx_port];
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q) begin
         txo_valid_q <= 1'h0;
         txo_tag_q   <= 1'h0;
         txo_tpid_q  <= `VLPF_TPID_C;
      end else begin
         txo_valid_q <= tx_valid;
         unique case (tx_ty)
            VLPF_UNAWARE, VLPF_CPORT: txo_tpid_q <= `VLPF_TPID_C;
            VLPF_SPORT:               txo_tpid_q <= `VLPF_TPID_S;
            VLPF_SCUST:               txo_tpid_q <= etype_q;
         endcase
         unique case (txtag_q[tx_port])
            VLPF_UNTAG_PVID: txo_tag_q <= (tx_vid != pvid_q[tx_port]);
            VLPF_TAG_ALL:    txo_tag_q <= 1'h1;
            default:         txo_tag_q <= 1'h0;
         endcase
      end
   end

   // management access gate
   logic mgmt_mem;
   assign mgmt_mem = vmem[mgmt_vid_q][mgmt_port];
   always_ff @(posedge clk_sys or negedge rs_n_q) begin
      if (!rs_n_q)
         mgmt_ok_q <= 1'h0;
      else
         mgmt_ok_q <= mgmt_valid && mgmt_mem;
   end

   // checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rs_n_q);

   a_untag_pvid: assert property (rx_valid && !rx_tagged && !tonly_q[rx_port]
      && !ifilt_q[rx_port] |=> !cls_drop_q && cls_vid_q == $past(src_pvid))
      else $error("untagged frame not given port vid");
   a_blind_push: assert property (rx_valid && rx_tagged && src_ty == VLPF_UNAWARE
      && rx_tpid == `VLPF_TPID_C |=> cls_push_q)
      else $error("tag-blind port did not push tag");
   a_c_tpid_drop: assert property (rx_valid && rx_tagged && rx_tpid != `VLPF_TPID_C
      && (src_ty == VLPF_UNAWARE || src_ty == VLPF_CPORT) |=> cls_drop_q && cls_dst_q == '0)
      else $error("foreign tpid not dropped");
   a_c_forward: assert property (rx_valid && rx_tagged && src_ty == VLPF_CPORT
      && rx_tpid == `VLPF_TPID_C && !ifilt_q[rx_port] |=> !cls_drop_q && cls_vid_q == $past(rx_vid))
      else $error("customer tagged frame not forwarded");
   a_s_tpid_drop: assert property (rx_valid && rx_tagged && rx_tpid != `VLPF_TPID_S
      && (src_ty == VLPF_SPORT || src_ty == VLPF_SCUST) |=> cls_drop_q)
      else $error("service port kept foreign tpid");
   a_tx_stpid: assert property (tx_valid && tx_ty == VLPF_SPORT
      |=> txo_valid_q && txo_tpid_q == `VLPF_TPID_S)
      else $error("service port tpid wrong");
   a_tx_custom: assert property (tx_valid && tx_ty == VLPF_SCUST
      |=> txo_tpid_q == $past(etype_q))
      else $error("custom service tpid wrong");
   a_tx_untag: assert property (tx_valid && txtag_q[tx_port] == VLPF_UNTAG_ALL
      |=> !txo_tag_q)
      else $error("untag-all port sent a tag");
   a_pv_member: assert property (rx_valid && !src_in_pv |=> cls_dst_q == '0)
      else $error("non-member source forwarded");
   a_iso_block: assert property (rx_valid && iso_q[rx_port]
      |=> (cls_dst_q & $past(iso_q)) == '0)
      else $error("isolated ports reached each other");
   a_pv_reject: assert property (wr_go && av_address == `VLPF_A_PCMD && pv_bad
      |=> rej_q && $stable(pv_val_q))
      else $error("out of range private vlan accepted");
   a_mgmt_gate: assert property (mgmt_valid && !mgmt_mem |=> !mgmt_ok_q)
      else $error("management from non-member port");
   a_bus_answer: assert property ((av_read || av_write) && av_waitrequest
      |=> !av_waitrequest ##1 av_waitrequest)
      else $error("waitrequest not one cycle low");

   cv_push: cover property (rx_valid && c_push ##1 cls_push_q);
   cv_drop: cover property (rx_valid && rx_tagged && c_drop);
   cv_iso:  cover property (rx_valid && iso_q[rx_port] && (c_vmask & reach & iso_q) != '0);
   cv_read: cover property (av_read && av_waitrequest ##1 !av_waitrequest);
endmodule : vlpf_top
`default_nettype wire

/* File: rtl/vlpf_regs.svh */
// register offsets, field positions and reset values of the vlan port filter
`ifndef VLPF_REGS_SVH
`define VLPF_REGS_SVH
`define VLPF_A_ETYPE  8'h00
`define VLPF_A_MGMT   8'h04
`define VLPF_A_ISO    8'h08
`define VLPF_A_STAT   8'h0C
`define VLPF_A_VSEL   8'h10
`define VLPF_A_VMASK  8'h14
`define VLPF_A_PCMD   8'h18
`define VLPF_A_PMASK  8'h1C
`define VLPF_A_PORT0  8'h40
`define VLPF_F_TYPE   1:0
`define VLPF_F_TXTAG  3:2
`define VLPF_F_IFILT  4
`define VLPF_F_TONLY  5
`define VLPF_F_PVID   27:16
`define VLPF_F_VID    11:0
`define VLPF_F_PVOP   9:8
`define VLPF_F_PVID8  7:0
`define VLPF_F_PVVAL  31
`define VLPF_F_REJ    0
`define VLPF_F_DCNT   31:16
`define VLPF_F_ETYPE  15:0
`define VLPF_OP_NEW   2'h1
`define VLPF_OP_DEL   2'h2
`define VLPF_TPID_C   16'h8100
`define VLPF_TPID_S   16'h88A8
`define VLPF_RST_VID  12'h001
`define VLPF_RST_ETY  16'h88A8
`define VLPF_VID_NONE 12'h000
`endif

/* File: rtl/vlpf_pkg.sv */
// types shared by the vlan port filter
package vlpf_pkg;
   typedef logic [15:0] vlpf_tpid_t;
   typedef logic [11:0] vlpf_vid_t;
   typedef enum logic [1:0] {
      VLPF_UNAWARE = 2'h0, VLPF_CPORT = 2'h1, VLPF_SPORT = 2'h2, VLPF_SCUST = 2'h3
   } vlpf_ptype_e;
   typedef enum logic [1:0] {
      VLPF_UNTAG_PVID = 2'h0, VLPF_TAG_ALL = 2'h1, VLPF_UNTAG_ALL = 2'h2
   } vlpf_txtag_e;
endpackage : vlpf_pkg

/* File: verif/vlpf_station.sv */
// remote station model that delivers frame headers to the filter
`timescale 1ns/1ps
`default_nettype none
module vlpf_station (
   input  wire logic            clk_sys,
   output logic                 rx_valid,
   output logic [2:0]           rx_port,
   output logic                 rx_tagged,
   output vlpf_pkg::vlpf_tpid_t rx_tpid,
   output vlpf_pkg::vlpf_vid_t  rx_vid
);
   import vlpf_pkg::*;

   // idle header lines, nothing valid yet
   initial begin
      rx_valid  = 1'b0;
      rx_port   = 3'h0;
      rx_tagged = 1'b0;
      rx_tpid   = 16'h0000;
      rx_vid    = 12'h000;
   end

   // one header pulse; afterwards the stale fields are inverted so nothing relies on them
   task automatic send(input logic [2:0] p, input logic t, input logic [15:0] tp,
                       input logic [11:0] v);
      @(posedge clk_sys);
      rx_valid  <= 1'b1;
      rx_port   <= p;
      rx_tagged <= t;
      rx_tpid   <= tp;
      rx_vid    <= v;
      @(posedge clk_sys);
      rx_valid  <= 1'b0;
      rx_port   <= ~p;
      rx_tagged <= ~t;
      rx_tpid   <= ~tp;
      rx_vid    <= ~v;
   endtask : send
endmodule : vlpf_station
`default_nettype wire

/* File: verif/test_vlan_port_tag_and_private_vlan_filter.sv */
// self-checking bench for the vlan port filter
`timescale 1ns/1ps
`default_nettype none
`include "vlpf_regs.svh"
module test_vlan_port_tag_and_private_vlan_filter;
   import vlpf_pkg::*;
   logic        clk_sys, rstn, av_read, av_write, av_waitrequest;
   logic [7:0]  av_address;
   logic [31:0] av_writedata, av_readdata, rd;
   logic        rx_valid, rx_tagged, cls_valid_q, cls_drop_q, cls_push_q;
   logic [2:0]  rx_port, tx_port, mgmt_port;
   vlpf_tpid_t  rx_tpid, txo_tpid_q;
   vlpf_vid_t   rx_vid, cls_vid_q, tx_vid;
   logic [7:0]  cls_dst_q;
   logic        tx_valid, txo_valid_q, txo_tag_q, mgmt_valid, mgmt_ok_q;
   int          fail_count = 0;
   int          check_count = 0;

   vlpf_top #(.NPORT(8)) u_dut (.clk_sys(clk_sys), .rstn(rstn), .av_address(av_address),
      .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .rx_valid(rx_valid),
      .rx_port(rx_port), .rx_tagged(rx_tagged), .rx_tpid(rx_tpid), .rx_vid(rx_vid),
      .cls_valid_q(cls_valid_q), .cls_drop_q(cls_drop_q), .cls_push_q(cls_push_q),
      .cls_vid_q(cls_vid_q), .cls_dst_q(cls_dst_q), .tx_valid(tx_valid), .tx_port(tx_port),
      .tx_vid(tx_vid), .txo_valid_q(txo_valid_q), .txo_tag_q(txo_tag_q),
      .txo_tpid_q(txo_tpid_q), .mgmt_valid(mgmt_valid), .mgmt_port(mgmt_port),
      .mgmt_ok_q(mgmt_ok_q));
   vlpf_station u_peer (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_port(rx_port),
      .rx_tagged(rx_tagged), .rx_tpid(rx_tpid), .rx_vid(rx_vid));

   // 20 mhz clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : print_verdict

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one avalon access; held until waitrequest is sampled low at a rising edge,
   // data taken and request released at that same edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys);
      av_write <= wr;
      av_read <= ~wr;
      av_address <= a;
      av_writedata <= d;
      for (n = 0; n < 20; n++) begin
         @(posedge clk_sys);
         if (av_waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         fail_count++;
         print_verdict();
      end
      rd = av_readdata;
      av_write <= 1'b0;
      av_read <= 1'b0;
   endtask : bus

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask : rdc

   task automatic rxc(input logic [2:0] p, input logic t, input logic [15:0] tp,
                      input logic [11:0] v, input logic d, input logic pu,
                      input logic [11:0] ev, input logic [7:0] ed);
      u_peer.send(p, t, tp, v);
      #1;
      chk("cls_valid", cls_valid_q, 1'b1);
      chk("cls_drop", cls_drop_q, d);
      chk("cls_push", cls_push_q, pu);
      if (!d) chk("cls_vid", cls_vid_q, ev);
      chk("cls_dst", cls_dst_q, ed);
   endtask : rxc

   task automatic txc(input logic [2:0] p, input logic [11:0] v, input logic tg,
                      input logic [15:0] tp);
      @(posedge clk_sys);
      tx_valid <= 1'b1;
      tx_port <= p;
      tx_vid <= v;
      @(posedge clk_sys);
      tx_valid <= 1'b0;
      #1;
      chk("txo_valid", txo_valid_q, 1'b1);
      chk("txo_tag", txo_tag_q, tg);
      chk("txo_tpid", txo_tpid_q, tp);
   endtask : txc

   task automatic mgc(input logic [2:0] p, input logic ok);
      @(posedge clk_sys);
      mgmt_valid <= 1'b1;
      mgmt_port <= p;
      @(posedge clk_sys);
      mgmt_valid <= 1'b0;
      #1;
      chk("mgmt_ok", mgmt_ok_q, ok);
   endtask : mgc

   task automatic sc_reset_values;
      for (int p = 0; p < 8; p++) rdc("port", `VLPF_A_PORT0 + 8'(4 * p), 32'h0001_0000);
      rdc("etype", `VLPF_A_ETYPE, 32'h0000_88A8);
      rdc("iso", `VLPF_A_ISO, 32'h0);
      rdc("vmask", `VLPF_A_VMASK, 32'h0000_00FF);
      rdc("pmask", `VLPF_A_PMASK, 32'h8000_00FF);
      rdc("unmapped", 8'h30, 32'h0);
   endtask : sc_reset_values

   task automatic sc_ingress;
      rxc(3'h0, 1'b0, 16'h0000, 12'h000, 1'b0, 1'b0, 12'h001, 8'hFE);
      rxc(3'h0, 1'b1, 16'h8100, 12'h009, 1'b0, 1'b1, 12'h001, 8'hFE);
      rxc(3'h0, 1'b1, 16'h88A8, 12'h009, 1'b1, 1'b0, 12'h000, 8'h00);
      bus(1'b1, 8'h44, 32'h0001_0001);
      bus(1'b1, 8'h48, 32'h0001_0002);
      bus(1'b1, 8'h4C, 32'h0001_0003);
      rxc(3'h1, 1'b1, 16'h8100, 12'h005, 1'b0, 1'b0, 12'h005, 8'h00);
      rxc(3'h1, 1'b1, 16'h88A8, 12'h001, 1'b1, 1'b0, 12'h000, 8'h00);
      rxc(3'h2, 1'b1, 16'h88A8, 12'h001, 1'b0, 1'b0, 12'h001, 8'hFB);
      rxc(3'h2, 1'b1, 16'h8100, 12'h001, 1'b1, 1'b0, 12'h000, 8'h00);
      rxc(3'h3, 1'b1, 16'h8100, 12'h001, 1'b1, 1'b0, 12'h000, 8'h00);
      rxc(3'h3, 1'b0, 16'h0000, 12'h000, 1'b0, 1'b0, 12'h001, 8'hF7);
   endtask : sc_ingress

   task automatic sc_egress;
      txc(3'h1, 12'h001, 1'b0, 16'h8100);
      txc(3'h2, 12'h001, 1'b0, 16'h88A8);
      bus(1'b1, `VLPF_A_ETYPE, 32'h0000_1234);
      txc(3'h3, 12'h005, 1'b1, 16'h1234);
      txc(3'h0, 12'h005, 1'b1, 16'h8100);
      bus(1'b1, `VLPF_A_PORT0, 32'h0001_0004);
      txc(3'h0, 12'h001, 1'b1, 16'h8100);
      bus(1'b1, `VLPF_A_PORT0, 32'h0001_0008);
      txc(3'h0, 12'h005, 1'b0, 16'h8100);
      bus(1'b1, `VLPF_A_PORT0, 32'h0FFF_0000);
      rdc("pvid_max", `VLPF_A_PORT0, 32'h0FFF_0000);
      bus(1'b1, `VLPF_A_PORT0, 32'h0000_0000);
      rdc("pvid_zero", `VLPF_A_PORT0, 32'h0FFF_0000);
      bus(1'b1, `VLPF_A_PORT0, 32'h0001_0000);
   endtask : sc_egress

   task automatic sc_filters;
      bus(1'b1, 8'h44, 32'h0001_0011);
      rxc(3'h1, 1'b1, 16'h8100, 12'h005, 1'b1, 1'b0, 12'h000, 8'h00);
      bus(1'b1, `VLPF_A_VSEL, 32'h0000_0005);
      bus(1'b1, `VLPF_A_VMASK, 32'h0000_0002);
      rxc(3'h1, 1'b1, 16'h8100, 12'h005, 1'b0, 1'b0, 12'h005, 8'h00);
      bus(1'b1, 8'h50, 32'h0001_0020);
      rxc(3'h4, 1'b0, 16'h0000, 12'h000, 1'b1, 1'b0, 12'h000, 8'h00);
      rxc(3'h4, 1'b1, 16'h8100, 12'h003, 1'b0, 1'b1, 12'h001, 8'hEF);
      mgc(3'h0, 1'b1);
      bus(1'b1, `VLPF_A_MGMT, 32'h0000_0005);
      mgc(3'h0, 1'b0);
      mgc(3'h1, 1'b1);
   endtask : sc_filters

   task automatic sc_private;
      bus(1'b1, `VLPF_A_PCMD, 32'h0000_0100);
      rdc("reject_id0", `VLPF_A_STAT, 32'h0006_0001);
      bus(1'b1, `VLPF_A_STAT, 32'h0000_0001);
      rdc("reject_clr", `VLPF_A_STAT, 32'h0006_0000);
      bus(1'b1, `VLPF_A_PCMD, 32'h0000_0109);
      rdc("reject_id9", `VLPF_A_STAT, 32'h0006_0001);
      bus(1'b1, `VLPF_A_PCMD, 32'h0000_0102);
      rdc("pv_new", `VLPF_A_PMASK, 32'h8000_0000);
      bus(1'b1, `VLPF_A_PMASK, 32'h0000_0003);
      bus(1'b1, `VLPF_A_PCMD, 32'h0000_0201);
      rxc(3'h0, 1'b0, 16'h0000, 12'h000, 1'b0, 1'b0, 12'h001, 8'h02);
      rxc(3'h5, 1'b0, 16'h0000, 12'h000, 1'b0, 1'b0, 12'h001, 8'h00);
      bus(1'b1, `VLPF_A_PCMD, 32'h0000_0002);
      bus(1'b1, `VLPF_A_PMASK, 32'h0000_0007);
      bus(1'b1, `VLPF_A_ISO, 32'h0000_0003);
      rdc("iso_rb", `VLPF_A_ISO, 32'h0000_0003);
      rxc(3'h0, 1'b0, 16'h0000, 12'h000, 1'b0, 1'b0, 12'h001, 8'h04);
      rxc(3'h2, 1'b0, 16'h0000, 12'h000, 1'b0, 1'b0, 12'h001, 8'h03);
   endtask : sc_private

   // reset, then the scenarios in order
   initial begin
      rstn = 1'b0;
      {av_read, av_write, tx_valid, mgmt_valid} = 4'h0;
      av_address = 8'h00;
      av_writedata = 32'h0;
      {tx_port, mgmt_port} = 6'h0;
      tx_vid = 12'h000;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      sc_reset_values();
      sc_ingress();
      sc_egress();
      sc_filters();
      sc_private();
      print_verdict();
   end
endmodule : test_vlan_port_tag_and_private_vlan_filter
`default_nettype wire
